// file: design/adc_control.sv
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Contract
// [RQ1] reference select 000/1xx internal, 001 ext+, 010 ext-, 011 both.
// [RQ2] scan bit set scans channel zero positive input in first slot.
// [RQ3] channel count 00 converts channel zero; 01 channels zero and one.
// [RQ4] in twelve-bit mode channel count is unimplemented, reads zero.
// [RQ5] buffer-half status reads 1 while filling second half.
// [RQ6] rate n advances dma address or interrupts every (n+1)th conversion.
// [RQ7] split mode alternates buffer halves per event; else restarts at start.
// [RQ8] alternate bit toggles first/second slot selections per sample.
// [RQ9] pin bit 1: digital mode, port read enabled, mux tied to ground.
// [RQ10] pin bit 0: analog mode, port read disabled, converter samples pin.
// [RQ11] pin config bits 15..0 map to analog inputs 31..16.
// [RQ12] absent inputs keep readable bits but affect no port.
// [RQ13] second converter instance has no high pin config register.
// [RQ14] module disabled: pin bits ignored, all shared pins digital.
// [RQ15] unimplemented control bits ignore writes; fields reset to zero.
module adc_control #(
    parameter int INSTANCE = 1,
    parameter logic [15:0] INPUT_PRESENT = 16'hffff,
    parameter int RATE_W = 4
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CONV_DONE,
    output logic [1:0] REF_SEL,
    output logic SCAN_FIRST_SLOT,
    output logic [1:0] CHANNEL_COUNT,
    output logic USE_SECOND_SLOT,
    output logic BUFFER_SECOND_HALF,
    output logic RATE_EVENT,
    output logic [15:0] PIN_DIGITAL,
    output logic [15:0] PORT_READ_EN,
    output logic [15:0] MUX_TO_GROUND
);

    initial begin
        if (INSTANCE < 1 || INSTANCE > 2 || RATE_W != 4) begin
            $error("adc_control: unsupported parameters");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        adc_cfg_pkg::bus_state_t bus;
        logic [7:0] addr;
        logic [15:0] ctrl2;
        logic [15:0] pin_digital_select;
        logic [1:0] core;
        logic buf_half;
        logic alt_slot;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t st_r;
    ctl_state_t st_nxt;
    logic rate_pulse;
    logic twelve;
    logic disabled;
    logic has_high;
    logic [15:0] ctrl2_view;
    logic [2:0] ref_code;

    assign twelve = st_r.core[adc_cfg_pkg::TWELVE_BIT];
    assign disabled = st_r.core[adc_cfg_pkg::DISABLE_BIT];
    assign has_high = (INSTANCE == 1); // [RQ13]

    // read view of control 2 with live status merged
    always_comb begin
        ctrl2_view = st_r.ctrl2;
        if (twelve) begin
            ctrl2_view[adc_cfg_pkg::CHANNEL_COUNT_SELECT_LSB +: 2] = 2'h0; // [RQ4]
        end
        ctrl2_view[adc_cfg_pkg::BUFFER_HALF_STATUS_BIT] = st_r.buf_half; // [RQ5]
    end

    // ------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ------------------------------------------------------------
    logic take;
    logic [15:0] wdata16;

    assign take = HSEL && HREADY && HTRANS[1];
    assign wdata16 = HWDATA[15:0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.bus = adc_cfg_pkg::BUS_IDLE;
        case (st_r.bus)
            adc_cfg_pkg::BUS_WRITE: begin
                case (st_r.addr)
                    adc_cfg_pkg::OFS_CONTROL_2: begin
                        st_nxt.ctrl2 = wdata16 & adc_cfg_pkg::CTRL2_WMASK; // [RQ15]
                    end
                    adc_cfg_pkg::OFS_PIN_CFG_HIGH: begin
                        // absent inputs still store their bit
                        if (has_high) begin
                            st_nxt.pin_digital_select = wdata16; // [RQ12]
                        end
                    end
                    adc_cfg_pkg::OFS_CORE_CTRL: begin
                        st_nxt.core = wdata16[1:0];
                    end
                    default: begin
                    end
                endcase
            end
            adc_cfg_pkg::BUS_IDLE, adc_cfg_pkg::BUS_READ: begin
            end
            default: begin
            end
        endcase
        if (take) begin
            st_nxt.addr = {HADDR[7:2], 2'b00};
            st_nxt.bus = HWRITE ? adc_cfg_pkg::BUS_WRITE
                                : adc_cfg_pkg::BUS_READ;
            case ({HADDR[7:2], 2'b00})
                adc_cfg_pkg::OFS_CONTROL_2:
                    st_nxt.rdata = {16'h0000, ctrl2_view};
                adc_cfg_pkg::OFS_PIN_CFG_HIGH:
                    st_nxt.rdata = {16'h0000, st_r.pin_digital_select};
                adc_cfg_pkg::OFS_CORE_CTRL:
                    st_nxt.rdata = {30'h0, st_r.core};
                adc_cfg_pkg::OFS_CORE_STATUS:
                    st_nxt.rdata = {30'h0, st_r.alt_slot, st_r.buf_half};
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // buffer half flips on each event in split mode
        if (!st_r.ctrl2[adc_cfg_pkg::SPLIT_BIT]) begin
            st_nxt.buf_half = 1'b0; // [RQ7]
        end else if (rate_pulse) begin
            st_nxt.buf_half = ~st_r.buf_half; // [RQ7]
        end
        // sample slot alternation
        if (!st_r.ctrl2[adc_cfg_pkg::ALT_BIT]) begin
            st_nxt.alt_slot = 1'b0; // [RQ8]
        end else if (CONV_DONE) begin
            st_nxt.alt_slot = ~st_r.alt_slot; // [RQ8]
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r.bus <= adc_cfg_pkg::BUS_IDLE;
            st_r.addr <= 8'h00;
            st_r.ctrl2 <= adc_cfg_pkg::CTRL2_RESET; // [RQ15]
            st_r.pin_digital_select <= adc_cfg_pkg::PIN_DIGITAL_SELECT_RESET;
            st_r.core <= 2'h0;
            st_r.buf_half <= 1'b0;
            st_r.alt_slot <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign HRDATA = st_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ------------------------------------------------------------
    // conversion event rate
    // ------------------------------------------------------------
    adc_event_counter #(
        .WIDTH(RATE_W)
    ) u_rate (
        .MCLK(MCLK),
        .RSTN(RSTN),
        .rate(st_r.ctrl2[adc_cfg_pkg::RATE_LSB +: RATE_W]),
        .done(CONV_DONE),
        .event_pulse(rate_pulse)
    );

    // ------------------------------------------------------------
    // converter steering
    // ------------------------------------------------------------
    assign ref_code = st_r.ctrl2[adc_cfg_pkg::REF_LSB +: 3];

    always_comb begin
        case (ref_code)
            3'h1: REF_SEL = adc_cfg_pkg::REF_EXT_POS; // [RQ1]
            3'h2: REF_SEL = adc_cfg_pkg::REF_EXT_NEG; // [RQ1]
            3'h3: REF_SEL = adc_cfg_pkg::REF_EXT_BOTH; // [RQ1]
            default: REF_SEL = adc_cfg_pkg::REF_INTERNAL; // [RQ1]
        endcase
    end

    assign SCAN_FIRST_SLOT = st_r.ctrl2[adc_cfg_pkg::SCAN_BIT]; // [RQ2]
    // 12-bit mode is single channel only
    assign CHANNEL_COUNT = ctrl2_view[adc_cfg_pkg::CHANNEL_COUNT_SELECT_LSB +: 2]; // [RQ3]
    assign USE_SECOND_SLOT = st_r.alt_slot; // [RQ8]
    assign BUFFER_SECOND_HALF = st_r.buf_half; // [RQ7]
    assign RATE_EVENT = rate_pulse; // [RQ6]

    // ------------------------------------------------------------
    // pin configuration, bit i drives analog input 16+i
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pin
            logic dig;
            // absent or disabled: digital, no analog path
            assign dig = disabled || !has_high || !INPUT_PRESENT[i]
                         || st_r.pin_digital_select[i]; // [RQ9] [RQ11] [RQ12] [RQ14]
            assign PIN_DIGITAL[i] = dig; // [RQ9] [RQ10]
            assign PORT_READ_EN[i] = dig; // [RQ10]
            assign MUX_TO_GROUND[i] = dig; // [RQ9]
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_channel_count_select_twelve_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
        twelve |-> CHANNEL_COUNT == 2'h0) // [RQ4]
        else $error("channel count not zero in twelve-bit mode");

    a_disable_digital: assert property (@(posedge MCLK) disable iff (!RSTN)
        disabled |-> PIN_DIGITAL == 16'hffff) // [RQ14]
        else $error("pins not digital while disabled");

    a_split_toggle: assert property (@(posedge MCLK) disable iff (!RSTN)
        (rate_pulse && st_r.ctrl2[adc_cfg_pkg::SPLIT_BIT]
         && !(st_r.bus == adc_cfg_pkg::BUS_WRITE
              && st_r.addr == adc_cfg_pkg::OFS_CONTROL_2))
        |=> BUFFER_SECOND_HALF != $past(BUFFER_SECOND_HALF)) // [RQ7]
        else $error("buffer half did not alternate");

    a_alt_off_first: assert property (@(posedge MCLK) disable iff (!RSTN)
        !st_r.ctrl2[adc_cfg_pkg::ALT_BIT] |=> !USE_SECOND_SLOT
        || st_r.ctrl2[adc_cfg_pkg::ALT_BIT]) // [RQ8]
        else $error("second slot used with alternation off");

    a_ctrl2_mask: assert property (@(posedge MCLK) disable iff (!RSTN)
        (st_r.ctrl2 & ~adc_cfg_pkg::CTRL2_WMASK) == 16'h0000) // [RQ15]
        else $error("unimplemented control bit stored");

    a_ref_decode: assert property (@(posedge MCLK) disable iff (!RSTN)
        ref_code[2] |-> REF_SEL == adc_cfg_pkg::REF_INTERNAL) // [RQ1]
        else $error("upper reference codes not internal");

    a_pin_analog: assert property (@(posedge MCLK) disable iff (!RSTN)
        (!disabled && has_high && INPUT_PRESENT[0] && !st_r.pin_digital_select[0])
        |-> !PORT_READ_EN[0] && !MUX_TO_GROUND[0]) // [RQ10]
        else $error("analog pin has digital path");

    a_read_buffer_half_status: assert property (@(posedge MCLK) disable iff (!RSTN)
        (take && !HWRITE && HADDR[7:0] == adc_cfg_pkg::OFS_CONTROL_2)
        |=> HRDATA[adc_cfg_pkg::BUFFER_HALF_STATUS_BIT] == $past(st_r.buf_half)) // [RQ5]
        else $error("status bit read wrong");

endmodule

`default_nettype wire

// file: design/adc_cfg_pkg.sv
package adc_cfg_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_2 = 8'h00;
    localparam logic [7:0] OFS_PIN_CFG_HIGH = 8'h04;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h0c;

    // ------------------------------------------------------------
    // control 2 field layout
    // ------------------------------------------------------------
    localparam int REF_LSB = 13;
    localparam int SCAN_BIT = 10;
    localparam int CHANNEL_COUNT_SELECT_LSB = 8;
    localparam int BUFFER_HALF_STATUS_BIT = 7;
    localparam int RATE_LSB = 2;
    localparam int SPLIT_BIT = 1;
    localparam int ALT_BIT = 0;
    localparam logic [15:0] CTRL2_WMASK = 16'he73f;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [15:0] PIN_DIGITAL_SELECT_RESET = 16'h0000;

    // core control: bit0 twelve-bit mode, bit1 module disable
    localparam int TWELVE_BIT = 0;
    localparam int DISABLE_BIT = 1;

    // ------------------------------------------------------------
    // reference selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        REF_INTERNAL = 2'h0,
        REF_EXT_POS = 2'h1,
        REF_EXT_NEG = 2'h2,
        REF_EXT_BOTH = 2'h3
    } ref_sel_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_WRITE = 3'h2,
        BUS_READ = 3'h4
    } bus_state_t;

    typedef struct packed {
        ref_sel_t ref_sel;
        logic scan_first_slot;
        logic [1:0] channel_count;
        logic use_second_slot;
        logic buffer_second_half;
        logic rate_event;
    } conv_ctrl_t;

endpackage

// file: design/adc_event_counter.sv
`timescale 1ns/100ps
`default_nettype none

// counts completed conversions, flags every (n+1)th one
module adc_event_counter #(
    parameter int WIDTH = 4
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [WIDTH-1:0] rate,
    input wire logic done,
    output logic event_pulse
);

    initial begin
        if (WIDTH < 1 || WIDTH > 8) begin
            $error("adc_event_counter: WIDTH out of range");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic pulse;
    } cnt_state_t;

    cnt_state_t st_r;
    cnt_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.pulse = 1'b0;
        if (done) begin
            if (st_r.count >= rate) begin // [RQ6]
                st_nxt.count = '0;
                st_nxt.pulse = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign event_pulse = st_r.pulse;

    a_rate_zero_each: assert property (@(posedge MCLK) disable iff (!RSTN)
        (done && rate == '0) |=> event_pulse) // [RQ6]
        else $error("rate zero must flag every conversion");

endmodule

`default_nettype wire

// file: dv/adc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// conversion core: issues count completions, gap idle cycles apart
// ------------------------------------------------------------
module adc_core_model (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic go,
    input wire logic [4:0] count,
    input wire logic [3:0] gap,
    output logic busy,
    output logic conv_done
);
    int left;
    int wait_c;

    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            conv_done <= 1'b0;
            busy <= 1'b0;
            left = 0;
            wait_c = 0;
        end else begin
            conv_done <= 1'b0;
            if (go && left == 0) begin
                left = count;
                wait_c = 0;
            end
            if (left > 0 && wait_c == 0) begin
                conv_done <= 1'b1;
                left--;
                wait_c = gap;
            end else if (left > 0) begin
                wait_c--;
            end
            busy <= (left > 0);
        end
    end
endmodule
`default_nettype wire

// file: dv/test_adc_control_and_pin_config.sv
`timescale 1ns/100ps
`default_nettype none

module test_adc_control_and_pin_config;
    logic MCLK = 0;
    logic RSTN = 0;
    logic HSEL = 0;
    logic HWRITE = 0;
    logic go = 0;
    logic rd_pend = 0;
    logic [31:0] HADDR = 0;
    logic [31:0] HWDATA = 0;
    logic [1:0] HTRANS = 0;
    logic [4:0] cnt = 0;
    logic [3:0] gap = 0;
    logic [31:0] HRDATA;
    logic [1:0] REF_SEL;
    logic [1:0] CHANNEL_COUNT;
    logic [15:0] PIN_DIGITAL;
    logic [15:0] PORT_READ_EN;
    logic [15:0] MUX_TO_GROUND;
    logic [15:0] pin_digital_part;
    logic HREADYOUT, HRESP, SCAN_FIRST_SLOT, USE_SECOND_SLOT;
    logic BUFFER_SECOND_HALF, RATE_EVENT, CONV_DONE, busy;
    logic [31:0] q[$];
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int ev = 0;

    always #5 MCLK = ~MCLK;

    adc_control uut (.MCLK(MCLK), .RSTN(RSTN), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_DONE(CONV_DONE),
        .REF_SEL(REF_SEL), .SCAN_FIRST_SLOT(SCAN_FIRST_SLOT),
        .CHANNEL_COUNT(CHANNEL_COUNT), .USE_SECOND_SLOT(USE_SECOND_SLOT),
        .BUFFER_SECOND_HALF(BUFFER_SECOND_HALF), .RATE_EVENT(RATE_EVENT),
        .PIN_DIGITAL(PIN_DIGITAL), .PORT_READ_EN(PORT_READ_EN),
        .MUX_TO_GROUND(MUX_TO_GROUND));

    // part with only inputs 16..23 present: upper pin bits must stay digital
    adc_control #(.INPUT_PRESENT(16'h00ff)) uut_part (.MCLK(MCLK),
        .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(), .HREADYOUT(), .HRESP(),
        .CONV_DONE(CONV_DONE), .REF_SEL(), .SCAN_FIRST_SLOT(),
        .CHANNEL_COUNT(), .USE_SECOND_SLOT(), .BUFFER_SECOND_HALF(),
        .RATE_EVENT(), .PIN_DIGITAL(pin_digital_part), .PORT_READ_EN(),
        .MUX_TO_GROUND());

    adc_core_model core (.MCLK(MCLK), .RSTN(RSTN), .go(go), .count(cnt),
        .gap(gap), .busy(busy), .conv_done(CONV_DONE));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // read data is judged at the edge that closes the data phase
    always @(posedge MCLK) begin
        if (rd_pend && HREADYOUT === 1'b1) begin
            chk(HRDATA, q.pop_front(), "read data");
            chk({31'h0, HRESP}, 32'h0, "response");
        end
        if (RATE_EVENT === 1'b1) begin
            ev++;
        end
    end

    always @(posedge MCLK) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            $display("CHECK FAILED %0t cycle limit reached", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // bus master: single word, read notes its expectation
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rd_pend <= !w;
        if (!w) q.push_back(d);
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        rd_pend <= 1'b0;
        // idle cycle: an output check right after a write would see the old value
        @(posedge MCLK);
    endtask

    initial begin
        logic [31:0] n, p, h, s;
        int e0;
        void'($urandom(32'hd7886d08));
        repeat (2) @(posedge MCLK);
        RSTN <= 1'b1;
        @(posedge MCLK);
        bus(0, adc_cfg_pkg::OFS_CONTROL_2, 32'h0);
        bus(0, adc_cfg_pkg::OFS_PIN_CFG_HIGH, 32'h0);
        bus(1, adc_cfg_pkg::OFS_CONTROL_2, 32'hffffffff);
        bus(0, adc_cfg_pkg::OFS_CONTROL_2, 32'h0000e73f);
        bus(1, 8'h40, 32'h12345678);
        bus(0, 8'h40, 32'h0);
        $display("test reset and access done");
        for (int c = 0; c < 8; c++) begin
            bus(1, adc_cfg_pkg::OFS_CONTROL_2,
                (c << 13) | ((c & 1) << 10) | ((c & 3) << 8));
            chk(REF_SEL, c[2] ? 0 : c & 3, "ref");
            chk(SCAN_FIRST_SLOT, c & 1, "scan");
            chk(CHANNEL_COUNT, c & 3, "count");
        end
        $display("test reference codes done");
        bus(1, adc_cfg_pkg::OFS_CORE_CTRL, 32'h1);
        bus(1, adc_cfg_pkg::OFS_CONTROL_2, 32'h0100);
        chk(CHANNEL_COUNT, 0, "twelve bit count");
        bus(0, adc_cfg_pkg::OFS_CONTROL_2, 32'h0);
        bus(1, adc_cfg_pkg::OFS_CORE_CTRL, 32'h0);
        chk(CHANNEL_COUNT, 1, "count back");
        $display("test twelve bit mode done");
        h = 0;
        s = 0;
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? $urandom % 15 : 15;
            bus(1, adc_cfg_pkg::OFS_CONTROL_2, (n << 2) | 3);
            e0 = ev;
            cnt <= n + 1;
            gap <= $urandom % 4;
            go <= 1'b1;
            @(posedge MCLK);
            go <= 1'b0;
            @(posedge MCLK);
            while (busy) @(posedge MCLK);
            repeat (3) @(posedge MCLK);
            h ^= 1;
            s ^= (n + 1) & 1;
            chk(ev - e0, 1, "events");
            chk(BUFFER_SECOND_HALF, h, "half");
            chk(USE_SECOND_SLOT, s, "slot");
            bus(0, adc_cfg_pkg::OFS_CONTROL_2, (n << 2) | 3 | (h << 7));
        end
        $display("test rate and buffer done");
        p = $urandom & 32'hffff;
        bus(1, adc_cfg_pkg::OFS_PIN_CFG_HIGH, p);
        chk(PIN_DIGITAL, p, "digital");
        chk(PORT_READ_EN, p, "read enable");
        chk(MUX_TO_GROUND, p, "ground");
        chk(pin_digital_part, p | 32'hff00, "absent inputs");
        bus(0, adc_cfg_pkg::OFS_PIN_CFG_HIGH, p);
        bus(1, adc_cfg_pkg::OFS_CORE_CTRL, 32'h2);
        chk(PIN_DIGITAL, 32'hffff, "disabled");
        chk(PORT_READ_EN, 32'hffff, "disabled read");
        bus(0, adc_cfg_pkg::OFS_PIN_CFG_HIGH, p);
        $display("test pin configuration done");
        conclude();
    end
endmodule
`default_nettype wire
